// ### rtl/gcs_pkg.sv
package gcs_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NET_NUM = 16;
   localparam int SIDE_NUM = 4;
   localparam int PLL_NUM = 4;
   localparam int PLL_OUTS = 3;
   localparam int CLK_PINS = 16;
   localparam int DP_DIRECT = 12;
   localparam int CORNER_PINS = 8;
   localparam int INT_SIG = 64;
   localparam int CFG_W = 14;
   localparam int SYNC_W = 50;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_NET_CFG = 8'h00;
   localparam logic [7:0] ADDR_NET_CFG_LAST = 8'h3c;
   localparam logic [7:0] ADDR_REF_CFG = 8'h40;
   localparam logic [7:0] ADDR_CORNER_CFG = 8'h44;
   localparam logic [7:0] ADDR_STATUS = 8'h48;

   // ------------------------------------------------------------
   // Network configuration word fields
   // ------------------------------------------------------------
   localparam int F_CLK_A = 0;
   localparam int F_CLK_B = 2;
   localparam int F_PLL_A = 4;
   localparam int F_PLL_B = 6;
   localparam int F_DP = 8;
   localparam int F_INT = 10;
   localparam int F_STATIC = 12;
   localparam int F_STATIC_SRC = 13;

   // Reference configuration fields
   localparam int F_REF_SEL = 0;
   localparam int F_REF_MANUAL = 4;

   // Status fields
   localparam int F_ST_USER = 16;
   localparam int F_ST_LARGE = 17;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CFG_W-1:0] NET_CFG_RST = 14'h0044;
   localparam logic [7:0] REF_CFG_RST = 8'h00;
   localparam logic [3:0] CORNER_CFG_RST = 4'h0;

   // ------------------------------------------------------------
   // Active source codes
   // ------------------------------------------------------------
   localparam logic [2:0] SRC_DP = 3'h4;
   localparam logic [2:0] SRC_INT = 3'h5;
   localparam logic [1:0] PLL_PICK_MAX = 2'h2;

endpackage : gcs_pkg

// ### rtl/gcs_top.sv
// Summary of operation
// - One control block per global network, each driving only its own network, sixteen.
// - Large variant uses all sixteen blocks; small variant only left and right sides.
// - Candidates: four side clock pins, three PLL outputs, four dual pins, four internals.
// - Six inputs enter selection: two clock pins, two PLL, one dual, one internal.
// - Only the two clock pins and two PLL outputs are selectable at run time.
// - Dual-purpose versus internal choice is static, fixed by configuration.
// - Static selections come from configuration only; user-mode writes are ignored.
// - Fabric enable input turns each global network on or off.
// - Reference switch picks one of two clock pins as PLL reference, static or manual.
// - Per corner only one corner dual pin feeds blocks; others stay general I/O.
// - Corner dual pins pass an extra mux stage, adding delay.
// - Unused clock pins feed fabric as plain inputs, without an I/O register.
// - Large variant has twenty dual pins; small variant eight, two per side.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none

module gcs_top
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Pins
   input wire logic [gcs_pkg::CLK_PINS-1:0] clk_pin_i,
   input wire logic [gcs_pkg::PLL_NUM*gcs_pkg::PLL_OUTS-1:0] pll_out_i,
   input wire logic [gcs_pkg::DP_DIRECT-1:0] dual_purpose_pin_i,
   input wire logic [gcs_pkg::CORNER_PINS-1:0] corner_dual_purpose_pin_i,
   input wire logic user_mode_i,
   input wire logic variant_large_i,
   // Fabric
   input wire logic [gcs_pkg::INT_SIG-1:0] internal_sig_i,
   input wire logic [2*gcs_pkg::NET_NUM-1:0] dynamic_source_select_i,
   input wire logic [gcs_pkg::NET_NUM-1:0] network_enable_i,
   input wire logic [gcs_pkg::PLL_NUM-1:0] reference_switch_select_i,
   output logic [gcs_pkg::NET_NUM-1:0] global_network_o,
   output logic [gcs_pkg::PLL_NUM-1:0] pll_ref_o,
   output logic [gcs_pkg::CLK_PINS-1:0] clk_pin_fabric_o,
   output logic [gcs_pkg::CORNER_PINS-1:0] corner_pin_fabric_o
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [gcs_pkg::SYNC_W-1:0] sync1_r;
   logic [gcs_pkg::SYNC_W-1:0] sync2_r;
   logic [gcs_pkg::CLK_PINS-1:0] clk_pin_s;
   logic [gcs_pkg::PLL_NUM*gcs_pkg::PLL_OUTS-1:0] pll_s;
   logic [gcs_pkg::DP_DIRECT-1:0] dp_s;
   logic [gcs_pkg::CORNER_PINS-1:0] corner_s;
   logic user_mode_s;
   logic large_s;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else if (ce_i)
      begin
         sync1_r <= {variant_large_i, user_mode_i, corner_dual_purpose_pin_i,
                     dual_purpose_pin_i, pll_out_i, clk_pin_i};
         sync2_r <= sync1_r;
      end
   end

   assign clk_pin_s = sync2_r[15:0];
   assign pll_s = sync2_r[27:16];
   assign dp_s = sync2_r[39:28];
   assign corner_s = sync2_r[47:40];
   assign user_mode_s = sync2_r[48];
   assign large_s = sync2_r[49];

   // Plain fabric inputs straight off the synchroniser
   assign clk_pin_fabric_o = clk_pin_s;
   assign corner_pin_fabric_o = corner_s;

   // ------------------------------------------------------------
   // Variant strap
   // ------------------------------------------------------------
   logic large_r;

   // Follows the strap until user mode begins, then holds
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         large_r <= 1'b0;
      else if (ce_i && !user_mode_s)
         large_r <= large_s;
   end

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   logic [gcs_pkg::CFG_W-1:0] cfg_r [gcs_pkg::NET_NUM];
   logic [gcs_pkg::CFG_W-1:0] cfg_nxt [gcs_pkg::NET_NUM];
   logic [7:0] ref_cfg_r;
   logic [7:0] ref_cfg_nxt;
   logic [3:0] corner_cfg_r;
   logic [3:0] corner_cfg_nxt;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rd_val;
   logic [gcs_pkg::NET_NUM-1:0] act_en;
   logic addr_take;
   logic static_wr;

   assign addr_take = hsel_i && hready_i && htrans_i[1];
   assign static_wr = wr_pend_r && !user_mode_s;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else if (ce_i)
      begin
         wr_pend_r <= addr_take && hwrite_i;
         if (addr_take)
            wr_addr_r <= haddr_i[7:0];
      end
   end

   // Next values, also used for reads so a read after a write sees it
   always_comb
   begin
      ref_cfg_nxt = ref_cfg_r;
      corner_cfg_nxt = corner_cfg_r;
      for (int i = 0; i < gcs_pkg::NET_NUM; i++)
      begin
         cfg_nxt[i] = cfg_r[i];
         if (static_wr && wr_addr_r[7:6] == 2'h0 && wr_addr_r[5:2] == 4'(i))
            cfg_nxt[i] = hwdata_i[gcs_pkg::CFG_W-1:0];
      end
      if (static_wr && wr_addr_r == gcs_pkg::ADDR_REF_CFG)
         ref_cfg_nxt = hwdata_i[7:0];
      if (static_wr && wr_addr_r == gcs_pkg::ADDR_CORNER_CFG)
         corner_cfg_nxt = hwdata_i[3:0];
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int i = 0; i < gcs_pkg::NET_NUM; i++)
            cfg_r[i] <= gcs_pkg::NET_CFG_RST;
         ref_cfg_r <= gcs_pkg::REF_CFG_RST;
         corner_cfg_r <= gcs_pkg::CORNER_CFG_RST;
      end
      else if (ce_i)
      begin
         cfg_r <= cfg_nxt;
         ref_cfg_r <= ref_cfg_nxt;
         corner_cfg_r <= corner_cfg_nxt;
      end
   end

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (haddr_i[7:0] <= gcs_pkg::ADDR_NET_CFG_LAST)
         rd_val = {18'h0_0000, cfg_nxt[haddr_i[5:2]]};
      else if (haddr_i[7:0] == gcs_pkg::ADDR_REF_CFG)
         rd_val = {24'h00_0000, ref_cfg_nxt};
      else if (haddr_i[7:0] == gcs_pkg::ADDR_CORNER_CFG)
         rd_val = {28'h000_0000, corner_cfg_nxt};
      else if (haddr_i[7:0] == gcs_pkg::ADDR_STATUS)
         rd_val = {14'h0000, large_r, user_mode_s, act_en};
      if (haddr_i[31:8] != 24'h00_0000)
         rd_val = 32'h0000_0000;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
      else if (ce_i && addr_take && !hwrite_i)
         hrdata_o <= rd_val;
   end

   // ------------------------------------------------------------
   // Corner dual-purpose pin mux
   // ------------------------------------------------------------
   logic [3:0] corner_r;

   // Extra register stage models the longer corner path
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         corner_r <= 4'h0;
      else if (ce_i)
         for (int c = 0; c < 4; c++)
            corner_r[c] <= corner_s[2*c + int'(corner_cfg_r[c])];
   end

   // Per side: three direct pins plus the corner slot
   logic [15:0] dp_side;

   always_comb
   begin
      for (int s = 0; s < gcs_pkg::SIDE_NUM; s++)
      begin
         dp_side[4*s +: 3] = dp_s[3*s +: 3];
         dp_side[4*s + 3] = corner_r[s];
         // Small variant bonds out two pins per side
         if (!large_r)
            dp_side[4*s + 2 +: 2] = 2'b00;
      end
   end

   // ------------------------------------------------------------
   // PLL reference switch
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pll_ref_o <= '0;
      else if (ce_i)
         for (int p = 0; p < gcs_pkg::PLL_NUM; p++)
            if (!large_r && p >= 2)
               pll_ref_o[p] <= 1'b0;
            else if (ref_cfg_r[gcs_pkg::F_REF_MANUAL + p] ?
                     reference_switch_select_i[p] : ref_cfg_r[gcs_pkg::F_REF_SEL + p])
               pll_ref_o[p] <= clk_pin_s[4*p + 1];
            else
               pll_ref_o[p] <= clk_pin_s[4*p];
   end

   // ------------------------------------------------------------
   // Clock control blocks
   // ------------------------------------------------------------
   for (genvar n = 0; n < gcs_pkg::NET_NUM; n++)
   begin : g_net
      localparam int SIDE = n / 4;
      logic [gcs_pkg::CFG_W-1:0] cw;
      logic [5:0] cand;
      logic [2:0] sel_nxt;
      logic [1:0] pa;
      logic [1:0] pb;
      logic want;
      logic [2:0] sel_r;
      logic en_r;
      logic gn_r;

      assign cw = cfg_r[n];

      always_comb
      begin
         pa = (cw[gcs_pkg::F_PLL_A +: 2] > gcs_pkg::PLL_PICK_MAX) ?
              gcs_pkg::PLL_PICK_MAX : cw[gcs_pkg::F_PLL_A +: 2];
         pb = (cw[gcs_pkg::F_PLL_B +: 2] > gcs_pkg::PLL_PICK_MAX) ?
              gcs_pkg::PLL_PICK_MAX : cw[gcs_pkg::F_PLL_B +: 2];
         // Six inputs out of the fifteen candidates
         cand[0] = clk_pin_s[4*SIDE + int'(cw[gcs_pkg::F_CLK_A +: 2])];
         cand[1] = clk_pin_s[4*SIDE + int'(cw[gcs_pkg::F_CLK_B +: 2])];
         cand[2] = pll_s[3*SIDE + int'(pa)];
         cand[3] = pll_s[3*SIDE + int'(pb)];
         cand[4] = dp_side[4*SIDE + int'(cw[gcs_pkg::F_DP +: 2])];
         cand[5] = internal_sig_i[4*n + int'(cw[gcs_pkg::F_INT +: 2])];
         if (cw[gcs_pkg::F_STATIC])
            sel_nxt = cw[gcs_pkg::F_STATIC_SRC] ? gcs_pkg::SRC_INT : gcs_pkg::SRC_DP;
         else
            sel_nxt = {1'b0, dynamic_source_select_i[2*n +: 2]};
         want = network_enable_i[n] && (large_r || SIDE < 2);
      end

      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            sel_r <= 3'h0;
            en_r <= 1'b0;
            gn_r <= 1'b0;
         end
         else if (ce_i)
         begin
            gn_r <= en_r && cand[sel_r];
            // Switch only while output and new source are low and the old source is low or disabled
            if (!gn_r && (!en_r || !cand[sel_r]) && !cand[sel_nxt])
            begin
               sel_r <= sel_nxt;
               en_r <= want;
            end
         end
      end

      assign global_network_o[n] = gn_r;
      assign act_en[n] = en_r;
   end

endmodule : gcs_top

`default_nettype wire

// ### verif/gcs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port relations of the source selector
// ----------------------------------------
module gcs_assertions
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [15:0] clk_pin_i,
   input wire logic user_mode_i,
   input wire logic variant_large_i,
   input wire logic [15:0] network_enable_i,
   input wire logic [15:0] global_network_o,
   input wire logic [3:0] pll_ref_o,
   input wire logic [15:0] clk_pin_fabric_o
);
   logic [1:0] up_r;

   // Edges since reset, saturating
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         up_r <= 2'h0;
      else if (up_r != 2'h3)
         up_r <= up_r + 2'h1;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   ready_high_a: assert property (hreadyout_o)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp_o)
      else $error("error response");
   unmapped_zero_a: assert property (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i
      && haddr_i[7:0] == 8'h80 |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   pin_sync_a: assert property (up_r == 2'h3 && ce_i && $past(ce_i)
      |-> clk_pin_fabric_o == $past(clk_pin_i, 2))
      else $error("fabric pin copy wrong");
   enable_cause_a: assert property ($rose(global_network_o[0])
      |-> $past(network_enable_i[0]) || $past(network_enable_i[0], 2))
      else $error("network rose while disabled");
   small_nets_a: assert property ((!user_mode_i && !variant_large_i) [*6]
      |-> global_network_o[15:8] == 8'h00)
      else $error("small variant drives top or bottom");
   small_pll_a: assert property ((!user_mode_i && !variant_large_i) [*6]
      |-> pll_ref_o[3:2] == 2'h0)
      else $error("small variant drives upper references");
   ref_cause_a: assert property ($rose(pll_ref_o[0])
      |-> (|$past(clk_pin_i[1:0], 2)) || (|$past(clk_pin_i[1:0], 3)))
      else $error("reference rose without a pin");
endmodule : gcs_assertions
`default_nettype wire

// ### verif/gcs_fabric_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Fabric logic driving select and enable
// ----------------------------------------
module gcs_fabric_model
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic slow_i,
   input wire logic [15:0] en_req_i,
   input wire logic [31:0] sel_req_i,
   input wire logic [3:0] ref_req_i,
   output logic [15:0] network_enable_o,
   output logic [31:0] dynamic_source_select_o,
   output logic [3:0] reference_switch_select_o
);
   logic skip_r;

   // Slow mode takes requests every other cycle
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         skip_r <= 1'b0;
         network_enable_o <= 16'h0000;
         dynamic_source_select_o <= 32'h0;
         reference_switch_select_o <= 4'h0;
      end
      else
      begin
         skip_r <= slow_i & ~skip_r;
         if (!(slow_i & ~skip_r))
         begin
            network_enable_o <= en_req_i;
            dynamic_source_select_o <= sel_req_i;
            reference_switch_select_o <= ref_req_i;
         end
      end
   end
endmodule : gcs_fabric_model
`default_nettype wire

// ### verif/gcs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module gcs_tb_top;
   typedef struct packed {
      logic [3:0] net;
      logic [1:0] sel;
      logic en;
      logic [15:0] pin;
      logic [11:0] pll;
      logic exp;
   } gcs_row_type;
   logic clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, user_mode_i, variant_large_i, slow;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, dynamic_source_select_i, sel_req;
   logic [1:0] htrans_i;
   logic [15:0] clk_pin_i, global_network_o, clk_pin_fabric_o, en_req, network_enable_i;
   logic [11:0] pll_out_i;
   logic [63:0] internal_sig_i;
   logic [3:0] reference_switch_select_i, pll_ref_o, ref_req;
   logic ce_i;
   logic [11:0] dual_purpose_pin_i;
   logic [7:0] corner_dual_purpose_pin_i, corner_pin_fabric_o;
   gcs_row_type r;
   int errors;
   int n_checks;
   gcs_row_type rows [9] = '{
      '{4'h0, 2'h0, 1'b1, 16'h0001, 12'h000, 1'b1}, '{4'h0, 2'h0, 1'b1, 16'h0002, 12'h000, 1'b0},
      '{4'h0, 2'h1, 1'b1, 16'h0002, 12'h000, 1'b1}, '{4'h0, 2'h1, 1'b1, 16'h0001, 12'h000, 1'b0},
      '{4'h0, 2'h2, 1'b1, 16'h0000, 12'h249, 1'b1}, '{4'h0, 2'h2, 1'b1, 16'h0000, 12'h492, 1'b0},
      '{4'h0, 2'h3, 1'b1, 16'h0000, 12'h492, 1'b1}, '{4'h0, 2'h0, 1'b0, 16'h0001, 12'h000, 1'b0},
      '{4'h9, 2'h1, 1'b1, 16'h0200, 12'h000, 1'b1}};

   gcs_top gcs_top_i (.clk_i, .arst_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .clk_pin_i, .pll_out_i, .dual_purpose_pin_i, .corner_dual_purpose_pin_i,
      .user_mode_i, .variant_large_i, .internal_sig_i, .dynamic_source_select_i,
      .network_enable_i, .reference_switch_select_i, .global_network_o, .pll_ref_o,
      .clk_pin_fabric_o, .corner_pin_fabric_o);

   gcs_fabric_model gcs_fabric_model_i (.clk_i, .arst_n_i, .slow_i(slow), .en_req_i(en_req),
      .sel_req_i(sel_req), .ref_req_i(ref_req), .network_enable_o(network_enable_i),
      .dynamic_source_select_o(dynamic_source_select_i),
      .reference_switch_select_o(reference_switch_select_i));

   task automatic print_verdict();
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask : ahb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk("register", e, rd);
   endtask : rdchk

   task automatic refstep(input logic [15:0] pat, input logic e);
      clk_pin_i <= pat;
      cyc(6);
      chk("reference", {31'h0, e}, {31'h0, pll_ref_o[0]});
      clk_pin_i <= 16'h0;
      cyc(3);
   endtask : refstep

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      print_verdict();
   end

   initial
   begin
      {arst_n_i, hsel_i, hwrite_i, user_mode_i, slow, htrans_i, haddr_i, hwdata_i} = '0;
      {clk_pin_i, pll_out_i, internal_sig_i, en_req, sel_req, ref_req} = '0;
      {dual_purpose_pin_i, corner_dual_purpose_pin_i} = '0;
      ce_i = 1'b1;
      variant_large_i = 1'b1;
      errors = 0;
      n_checks = 0;
      cyc(8);
      chk("reset", 32'h0001_0000, {15'h0, hreadyout_o, global_network_o});
      arst_n_i <= 1'b1;
      cyc(1);
      rdchk(8'h00, 32'h44);
      rdchk(8'h40, 32'h0);
      rdchk(8'h44, 32'h0);
      ahb(1'b1, 8'h48, 32'hffff_ffff);
      rdchk(8'h48, 32'h0002_0000);
      ahb(1'b1, 8'h80, 32'hffff_ffff);
      rdchk(8'h80, 32'h0);
      ahb(1'b1, 8'h3c, 32'hffff_ffbf);
      rdchk(8'h3c, 32'h3fbf);
      ahb(1'b1, 8'h3c, 32'h44);
      ahb(1'b1, 8'h44, 32'h5);
      rdchk(8'h44, 32'h5);
      for (int i = 0; i < 9; i++)
      begin
         r = rows[i];
         slow <= i[0];
         en_req <= 16'(r.en) << r.net;
         sel_req <= 32'(r.sel) << (2 * r.net);
         cyc(5);
         clk_pin_i <= r.pin;
         pll_out_i <= r.pll;
         cyc(6);
         chk("network", {31'h0, r.exp}, {31'h0, global_network_o[r.net]});
         clk_pin_i <= 16'h0;
         pll_out_i <= 12'h0;
         cyc(6);
      end
      // Disable waits while the source is high
      en_req <= 16'h1;
      sel_req <= 32'h0;
      cyc(5);
      clk_pin_i <= 16'h1;
      cyc(6);
      en_req <= 16'h0;
      cyc(6);
      chk("held", 32'h1, {31'h0, global_network_o[0]});
      clk_pin_i <= 16'h0;
      cyc(6);
      clk_pin_i <= 16'h1;
      cyc(6);
      chk("disabled", 32'h0, {31'h0, global_network_o[0]});
      clk_pin_i <= 16'h0;
      en_req <= 16'hffff;
      variant_large_i <= 1'b0;
      cyc(8);
      clk_pin_i <= 16'hffff;
      cyc(6);
      chk("small", 32'h00ff, {16'h0, global_network_o});
      clk_pin_i <= 16'h0;
      en_req <= 16'h0;
      cyc(6);
      variant_large_i <= 1'b1;
      refstep(16'h1, 1'b1);
      ahb(1'b1, 8'h40, 32'h1);
      refstep(16'h2, 1'b1);
      refstep(16'h1, 1'b0);
      ahb(1'b1, 8'h40, 32'h10);
      ref_req <= 4'h1;
      refstep(16'h2, 1'b1);
      ref_req <= 4'h0;
      refstep(16'h2, 1'b0);
      ahb(1'b1, 8'h08, 32'h1300);
      en_req <= 16'h4;
      cyc(5);
      corner_dual_purpose_pin_i <= 8'h02;
      cyc(7);
      chk("corner", 32'h1, {31'h0, global_network_o[2]});
      chk("corner pin", 32'h02, {24'h0, corner_pin_fabric_o});
      corner_dual_purpose_pin_i <= 8'h01;
      cyc(7);
      chk("corner unpicked", 32'h0, {31'h0, global_network_o[2]});
      corner_dual_purpose_pin_i <= 8'h00;
      ahb(1'b1, 8'h08, 32'h1200);
      dual_purpose_pin_i <= 12'h004;
      variant_large_i <= 1'b0;
      cyc(8);
      chk("small dual", 32'h0, {31'h0, global_network_o[2]});
      variant_large_i <= 1'b1;
      cyc(8);
      chk("dual", 32'h1, {31'h0, global_network_o[2]});
      ce_i <= 1'b0;
      dual_purpose_pin_i <= 12'h000;
      cyc(6);
      chk("frozen", 32'h1, {31'h0, global_network_o[2]});
      ce_i <= 1'b1;
      cyc(6);
      chk("thawed", 32'h0, {31'h0, global_network_o[2]});
      en_req <= 16'h0;
      cyc(6);
      ahb(1'b1, 8'h04, 32'h3000);
      en_req <= 16'h2;
      cyc(5);
      internal_sig_i <= 64'h10;
      cyc(4);
      chk("static", 32'h1, {31'h0, global_network_o[1]});
      internal_sig_i <= 64'h0;
      user_mode_i <= 1'b1;
      cyc(6);
      ahb(1'b1, 8'h04, 32'h44);
      rdchk(8'h04, 32'h3000);
      rdchk(8'h48, 32'h0003_0002);
      print_verdict();
   end
endmodule : gcs_tb_top

bind gcs_top gcs_assertions gcs_assertions_i (.clk_i, .arst_n_i, .ce_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .clk_pin_i, .user_mode_i,
   .variant_large_i, .network_enable_i, .global_network_o, .pll_ref_o, .clk_pin_fabric_o);
`default_nettype wire
